//--- bench/wdt_far_model.sv
// Purpose: Core, sleep controller and oscillators beside the watchdog
// Assumes: Bench sets mode only while reset is held
// Notes: Oscillators run free, scaled far faster to keep runs short
`timescale 1ns/1ps
`default_nettype none
module wdt_far_model (
    input wire logic core_clk,
    output var wdt_pkg::wdt_mode_t mode,
    output var logic clr,
    output var logic sleep,
    output var logic lowOsc,
    output var logic midOsc
);
    import wdt_pkg::*;
    int div = 0;
    initial begin
        mode = 2'h3;
        clr = 1'b0;
        sleep = 1'b0;
    end
    // Low source period 4 cycles, mid source 6, so the source choice is visible
    always @(posedge core_clk) begin
        div <= div + 1;
        lowOsc <= (div % 4) >= 2;
        midOsc <= (div % 6) >= 3;
    end
    task automatic clearPulse();
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- bench/wdt_props.sv
// Purpose: Port assertions of the watchdog
// Assumes: Sees only wdt_top ports
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module wdt_props (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire wdt_pkg::wdt_addr_t regAddr,
    input wire logic regWr,
    input wire wdt_pkg::wdt_mode_t watchdogModeConfig,
    input wire logic watchdogClearInstruction,
    input wire logic sleepState,
    input wire logic wdtResetReq,
    input wire logic wakeReq,
    input wire logic wdtActive,
    input wire logic expiryFlagN,
    input wire logic powerDownFlagN,
    input wire logic watchdogResetFlagN
);
    import wdt_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    mode_off_a: assert property (watchdogModeConfig == 2'h0 |-> !wdtActive)
        else $error("off mode runs");
    mode_on_a: assert property (watchdogModeConfig == 2'h3 |-> wdtActive)
        else $error("on mode stopped");
    sleep_off_a: assert property (watchdogModeConfig == 2'h2 && sleepState && $past(sleepState)
        |-> !wdtActive) else $error("runs asleep");
    wake_cause_a: assert property (wakeReq |-> $past(sleepState, 2) && !wdtResetReq)
        else $error("wake while awake");
    reset_cause_a: assert property (wdtResetReq |-> !$past(sleepState, 2) && $past(wdtActive))
        else $error("reset while asleep");
    flags_low_a: assert property ((wdtResetReq || wakeReq)
        |-> !expiryFlagN && !powerDownFlagN && !watchdogResetFlagN) else $error("flags kept");
    clear_hold_a: assert property (watchdogClearInstruction
        |-> ##2 (!wdtResetReq && !wakeReq) [*8]) else $error("clear ignored");
    ctrl_clear_a: assert property (regWr && regAddr == 12'h80C
        |-> ##2 (!wdtResetReq && !wakeReq) [*8]) else $error("write kept count");
    cover property (wdtResetReq);
    cover property (wakeReq);
    cover property (watchdogClearInstruction ##1 wdtActive);
endmodule
bind wdt_top wdt_props uChk (.core_clk, .arst_n, .regAddr, .regWr, .watchdogModeConfig,
    .watchdogClearInstruction, .sleepState, .wdtResetReq, .wakeReq, .wdtActive,
    .expiryFlagN, .powerDownFlagN, .watchdogResetFlagN);
`default_nettype wire

//--- bench/wdt_top_test.sv
// Purpose: Self-checking bench of the watchdog
// Assumes: Mode changes only under reset
// Notes: Time-outs judged within 8 cycles early and 4 cycles late
`timescale 1ns/1ps
`default_nettype none
module wdt_top_test;
    import wdt_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    wdt_addr_t regAddr = '0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata, d;
    wdt_mode_t mode;
    logic clr, sleep, lowOsc, midOsc, rstReq, wake, active, expN, pwrDnN, rwN;
    int failures = 0;
    int check_count = 0;
    int reqs = 0;
    int n, q;
    logic [7:0] cv [5] = '{8'h00, 8'h02, 8'h3E, 8'h26, 8'h80};
    int tk [5] = '{128, 256, 128, 128, 192};
    wdt_mode_t mv [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2};
    logic [7:0] ev [6] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [5:0] sv = 6'b100000;
    logic [5:0] av = 6'b011100;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (rstReq === 1'b1 || wake === 1'b1) reqs <= reqs + 1;
    wdt_far_model far (.core_clk, .mode, .clr, .sleep, .lowOsc, .midOsc);
    wdt_top uut (.core_clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .watchdogModeConfig(mode), .watchdogClearInstruction(clr), .sleepState(sleep),
        .lowFreqOsc(lowOsc), .midFreqOsc(midOsc), .wdtResetReq(rstReq), .wakeReq(wake),
        .wdtActive(active), .expiryFlagN(expN), .powerDownFlagN(pwrDnN),
        .watchdogResetFlagN(rwN));
    task automatic wr(input wdt_addr_t a, input logic [7:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input wdt_addr_t a, output logic [7:0] v);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 v = regRdata;
        @(posedge core_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkIn(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected at %0t: %0d cycles", $time, got);
        end
    endtask
    // Bounded so a silent watchdog cannot hang the run
    task automatic waitOut(output int c);
        c = 0;
        while (rstReq !== 1'b1 && wake !== 1'b1 && c < 1500) begin
            @(posedge core_clk);
            #1 c++;
        end
    endtask
    task automatic restart(input wdt_mode_t m);
        arst_n <= 1'b0;
        far.mode <= m;
        @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #1_000_000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd(12'h80C, d);
        chk(d, 8'h16);
        rd(12'h80D, d);
        chk(d, 8'h07);
        rd(12'h80E, d);
        chk(d, 8'h00);
        wr(12'h80C, 8'hFF);
        rd(12'h80C, d);
        chk(d, 8'hBF);
        for (int i = 0; i < 5; i++) begin
            wr(12'h80C, cv[i]);
            waitOut(n);
            chkIn(n, tk[i] - 8, tk[i] + 4);
            chk({6'h0, wake, rstReq}, 8'h01);
            rd(12'h80D, d);
            chk(d, 8'h00);
            wr(12'h80D, 8'h07);
        end
        // Clears every 100 cycles beat the 128-cycle time-out
        wr(12'h80C, 8'h00);
        q = reqs;
        repeat (8) begin
            repeat (100) @(posedge core_clk);
            far.clearPulse();
        end
        chkIn(reqs - q, 0, 0);
        for (int i = 0; i < 6; i++) begin
            restart(mv[i]);
            far.sleep <= sv[i];
            wr(12'h80C, ev[i]);
            q = reqs;
            repeat (300) @(posedge core_clk);
            chk({6'h0, active, reqs != q}, {6'h0, av[i], av[i]});
            far.sleep <= 1'b0;
        end
        restart(2'h3);
        wr(12'h80C, 8'h00);
        far.sleep <= 1'b1;
        waitOut(n);
        chkIn(n, 120, 132);
        chk({6'h0, wake, rstReq}, 8'h02);
        chk({5'h00, rwN, pwrDnN, expN}, 8'h00);
        rd(12'h80D, d);
        chk(d, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- core/wdt_cnt_if.sv
// Purpose: Link between the watchdog control logic and its counter
// Assumes: One clock domain
// Notes: Tick and clear are one-cycle pulses, expire is a registered pulse
`timescale 1ns/1ps
`default_nettype none
interface wdt_cnt_if;
    import wdt_pkg::*;
    logic tick;
    logic clear;
    logic run;
    wdt_div_t divSel;
    logic expire;
    modport ctl (output tick, output clear, output run, output divSel, input expire);
    modport cnt (input tick, input clear, input run, input divSel, output expire);
endinterface
`default_nettype wire

//--- core/wdt_counter.sv
// Purpose: Prescaled time-out counter of the watchdog
// Assumes: Ticks arrive at most once per core clock
// Notes: Clear has priority over counting
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"
module wdt_counter (
    input wire logic core_clk,
    input wire logic arst_n,
    wdt_cnt_if.cnt cnt
);
    import wdt_pkg::*;

    wdt_cnt_t count_q;
    wdt_cnt_t count_d;
    logic expire_q;
    logic expire_d;
    wdt_cnt_t ratio;

    always_comb begin
        if (cnt.divSel > `WDT_DIV_MAX) begin
            ratio = `WDT_BASE_RATIO;
        end else begin
            ratio = `WDT_BASE_RATIO << cnt.divSel;
        end
    end

    always_comb begin
        count_d = count_q;
        expire_d = 1'b0;
        if (cnt.clear) begin
            count_d = '0;
        end else if (cnt.run && cnt.tick) begin
            if (wdt_cnt_t'(count_q + 24'h000001) == ratio) begin
                count_d = '0;
                expire_d = 1'b1;
            end else begin
                count_d = wdt_cnt_t'(count_q + 24'h000001);
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
            expire_q <= 1'b0;
        end else begin
            count_q <= count_d;
            expire_q <= expire_d;
        end
    end

    assign cnt.expire = expire_q;
endmodule
`default_nettype wire

//--- core/wdt_pkg.sv
// Purpose: Shared types of the watchdog block
// Assumes: Offsets and counts come from wdt_regs.svh
// Notes: Types only
`include "wdt_regs.svh"
package wdt_pkg;
    typedef logic [1:0] wdt_mode_t;
    typedef logic [`WDT_DIV_MSB-`WDT_DIV_LSB:0] wdt_div_t;
    typedef logic [`WDT_CNT_W-1:0] wdt_cnt_t;
    typedef logic [`WDT_ADDR_W-1:0] wdt_addr_t;
    typedef enum logic {
        PH_AWAKE,
        PH_ASLEEP
    } wdt_phase_t;
endpackage

//--- core/wdt_regs.svh
// Purpose: Offsets, field positions, reset values and counts of the watchdog block
// Assumes: Included by its bare name from every design file that needs it
// Notes: Definitions only
//
// Function
// - Mode 11 keeps the watchdog running awake and asleep, enable bit ignored.
// - Mode 10 runs the watchdog while awake and stops it during sleep.
// - Mode 01 lets the software enable bit start or stop the watchdog.
// - Mode 00 keeps the watchdog off always, enable bit ignored.
// - Prescale code 0 gives ratio 32, doubling per step to 8388608 at 18.
// - Prescale codes 19 to 31 behave as the minimum ratio of 32.
// - After reset the prescale select is 01011, a ratio of 65536.
// - Clock source bit picks mid-frequency oscillator at 1, low-frequency at 0.
// - Counter clears on reset, clear instruction, sleep entry, wake, control write.
// - Enabled during sleep, the counter restarts from zero after entry clear.
// - Time-out during sleep wakes the device instead of resetting it.
// - Time-out drives expiry, power-down and watchdog-reset flags low.
// - Uncleared time-out while awake and active requests a device reset.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

`define WDT_ADDR_W 12
`define WDT_CTRL_ADDR 12'h80C
`define WDT_STAT_ADDR 12'h80D

`define WDT_CS_BIT 7
`define WDT_RSV_BIT 6
`define WDT_DIV_MSB 5
`define WDT_DIV_LSB 1
`define WDT_SWEN_BIT 0
`define WDT_CTRL_RST 8'h16
`define WDT_DIV_RST 5'h0B
`define WDT_DIV_MAX 5'h12

`define WDT_EXP_BIT 0
`define WDT_PWRDN_BIT 1
`define WDT_WDRST_BIT 2
`define WDT_STAT_RST 3'h7

`define WDT_MODE_OFF 2'h0
`define WDT_MODE_SW 2'h1
`define WDT_MODE_AWAKE 2'h2
`define WDT_MODE_ON 2'h3

`define WDT_CNT_W 24
`define WDT_BASE_RATIO 24'h000020

`endif

//--- core/wdt_top.sv
// Purpose: Watchdog with mode decode, prescale select, sleep wake and status flags
// Assumes: Oscillator inputs are levels synchronous to core_clk and far slower than it
// Notes: Registers on a plain strobe port, read data one cycle after the strobe
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"
module wdt_top (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire wdt_pkg::wdt_addr_t regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire wdt_pkg::wdt_mode_t watchdogModeConfig,
    input wire logic watchdogClearInstruction,
    input wire logic sleepState,
    input wire logic lowFreqOsc,
    input wire logic midFreqOsc,
    output logic wdtResetReq,
    output logic wakeReq,
    output logic wdtActive,
    output logic expiryFlagN,
    output logic powerDownFlagN,
    output logic watchdogResetFlagN
);
    import wdt_pkg::*;

    wdt_cnt_if cntIf ();

    // Control register fields
    logic clkSel_q;
    logic clkSel_d;
    wdt_div_t divSel_q;
    wdt_div_t divSel_d;
    logic swEnable_q;
    logic swEnable_d;

    // Status flags, all active low
    logic expiry_q;
    logic expiry_d;
    logic powerDown_q;
    logic powerDown_d;
    logic rstFlag_q;
    logic rstFlag_d;

    // Read data and pulses
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic resetReq_q;
    logic resetReq_d;
    logic wake_q;
    logic wake_d;

    // Oscillator edge and sleep phase tracking
    logic lowPrev_q;
    logic lowPrev_d;
    logic midPrev_q;
    logic midPrev_d;
    wdt_phase_t phase_q;
    wdt_phase_t phase_d;

    logic ctrlWrite;
    logic statWrite;
    logic lowRise;
    logic midRise;
    logic oscTick;
    logic sleepEnter;
    logic sleepExit;
    logic active;

    assign ctrlWrite = regWr && (regAddr == `WDT_CTRL_ADDR);
    assign statWrite = regWr && (regAddr == `WDT_STAT_ADDR);

    // Each source keeps its own history, so a source change cannot add a false tick
    assign lowRise = lowFreqOsc && !lowPrev_q;
    assign midRise = midFreqOsc && !midPrev_q;
    assign oscTick = clkSel_q ? midRise : lowRise;

    assign sleepEnter = (phase_q == PH_AWAKE) && sleepState;
    assign sleepExit = (phase_q == PH_ASLEEP) && !sleepState;

    // Mode decode; the mode input is treated as static configuration
    always_comb begin
        case (watchdogModeConfig)
            `WDT_MODE_ON: active = 1'b1;
            `WDT_MODE_AWAKE: active = (phase_q == PH_AWAKE);
            `WDT_MODE_SW: active = swEnable_q;
            `WDT_MODE_OFF: active = 1'b0;
            default: active = 1'b0;
        endcase
    end

    // Counter hookup; a disabled counter holds its value
    assign cntIf.tick = oscTick;
    assign cntIf.run = active;
    assign cntIf.divSel = divSel_q;
    assign cntIf.clear = watchdogClearInstruction || sleepEnter || sleepExit
        || ctrlWrite;

    wdt_counter counter (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .cnt(cntIf.cnt)
    );

    // Sleep phase and oscillator history
    always_comb begin
        lowPrev_d = lowFreqOsc;
        midPrev_d = midFreqOsc;
        case (phase_q)
            PH_AWAKE: phase_d = sleepState ? PH_ASLEEP : PH_AWAKE;
            PH_ASLEEP: phase_d = sleepState ? PH_ASLEEP : PH_AWAKE;
            default: phase_d = PH_AWAKE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lowPrev_q <= 1'b0;
            midPrev_q <= 1'b0;
            phase_q <= PH_AWAKE;
        end else begin
            lowPrev_q <= lowPrev_d;
            midPrev_q <= midPrev_d;
            phase_q <= phase_d;
        end
    end

    // Control register
    always_comb begin
        clkSel_d = clkSel_q;
        divSel_d = divSel_q;
        swEnable_d = swEnable_q;
        if (ctrlWrite) begin
            clkSel_d = regWdata[`WDT_CS_BIT];
            divSel_d = regWdata[`WDT_DIV_MSB:`WDT_DIV_LSB];
            swEnable_d = regWdata[`WDT_SWEN_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clkSel_q <= 1'b0;
            divSel_q <= `WDT_DIV_RST;
            swEnable_q <= 1'b0;
        end else begin
            clkSel_q <= clkSel_d;
            divSel_q <= divSel_d;
            swEnable_q <= swEnable_d;
        end
    end

    // Time-out routing and status flags; hardware events win over a software write
    always_comb begin
        resetReq_d = 1'b0;
        wake_d = 1'b0;
        expiry_d = expiry_q;
        powerDown_d = powerDown_q;
        rstFlag_d = rstFlag_q;
        if (statWrite) begin
            expiry_d = regWdata[`WDT_EXP_BIT];
            powerDown_d = regWdata[`WDT_PWRDN_BIT];
            rstFlag_d = regWdata[`WDT_WDRST_BIT];
        end
        if (sleepEnter) begin
            expiry_d = 1'b1;
            powerDown_d = 1'b0;
        end
        if (cntIf.expire) begin
            expiry_d = 1'b0;
            powerDown_d = 1'b0;
            rstFlag_d = 1'b0;
            if (phase_q == PH_ASLEEP) begin
                wake_d = 1'b1;
            end else begin
                resetReq_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            expiry_q <= 1'b1;
            powerDown_q <= 1'b1;
            rstFlag_q <= 1'b1;
            resetReq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            expiry_q <= expiry_d;
            powerDown_q <= powerDown_d;
            rstFlag_q <= rstFlag_d;
            resetReq_q <= resetReq_d;
            wake_q <= wake_d;
        end
    end

    // Read port; reserved bit and unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        if (regRd) begin
            if (regAddr == `WDT_CTRL_ADDR) begin
                rdata_d[`WDT_CS_BIT] = clkSel_q;
                rdata_d[`WDT_DIV_MSB:`WDT_DIV_LSB] = divSel_q;
                rdata_d[`WDT_SWEN_BIT] = swEnable_q;
            end else if (regAddr == `WDT_STAT_ADDR) begin
                rdata_d[`WDT_EXP_BIT] = expiry_q;
                rdata_d[`WDT_PWRDN_BIT] = powerDown_q;
                rdata_d[`WDT_WDRST_BIT] = rstFlag_q;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;
    assign wdtResetReq = resetReq_q;
    assign wakeReq = wake_q;
    assign wdtActive = active;
    assign expiryFlagN = expiry_q;
    assign powerDownFlagN = powerDown_q;
    assign watchdogResetFlagN = rstFlag_q;
endmodule
`default_nettype wire
